// File: verilog/reprog_pkg.sv
// Constants for the reprogram transaction handler
package reprog_pkg;
    localparam logic [4:0] SA_HEADER = 5'h14;
    localparam logic [4:0] SA_DATA = 5'h15;
    localparam logic [4:0] SA_TRAILER = 5'h16;
    localparam logic [4:0] SA_STATUS = 5'h17;
    localparam int TM_HI = 15;
    localparam int TM_LO = 14;
    localparam int HT_HI = 13;
    localparam int HT_LO = 12;
    localparam int CNT_HI = 11;
    localparam int PAGE_LO = 3;
    localparam int PAGE_ZERO_BIT = 2;
    localparam int SPC_LO = 8;
    localparam logic [1:0] TM_NONE = 2'h0;
    localparam logic [1:0] TM_8 = 2'h1;
    localparam logic [1:0] TM_16 = 2'h2;
    localparam logic [1:0] TM_32 = 2'h3;
    localparam logic [1:0] HT_WORDS = 2'h0;
    localparam logic [1:0] HT_MSGS = 2'h1;
    localparam logic [1:0] TC_LAST = 2'h0;
    localparam logic [1:0] TC_MORE = 2'h1;
    localparam logic [1:0] TC_JUMP = 2'h2;
    localparam logic [1:0] TC_BAD = 2'h3;
    localparam logic [12:0] COUNT_ZERO_MEANS = 13'h1000;
    localparam logic [15:0] STATUS_ERR_RETRY = 16'h8003;
    localparam logic [15:0] STATUS_OK = 16'h0000;
    localparam logic [15:0] SUM_RESET = 16'h0000;
endpackage

// File: verilog/data_fifo.sv
// Word FIFO between the bus receiver and the memory write port
`timescale 1ns/100ps
module data_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
    logic doWr, doRd;
    always_comb begin
        inReady = (wrPtr - rdPtr) != (AW+1)'(DEPTH);
        outValid = wrPtr != rdPtr;
        outData = mem[rdPtr[AW-1:0]];
        doWr = inValid && inReady && clkEn;
        doRd = outValid && outReady && clkEn;
        next_wrPtr = doWr ? wrPtr + 1'b1 : wrPtr;
        next_rdPtr = doRd ? rdPtr + 1'b1 : rdPtr;
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
        end else begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
        end
        if (doWr) begin
            mem[wrPtr[AW-1:0]] <= inData;
        end
    end
endmodule

// File: verilog/reprogram_transaction_handler.sv
// Remote-terminal handler for header, data, trailer and status messages
`timescale 1ns/100ps
module reprogram_transaction_handler
    import reprog_pkg::*;
#(
    parameter int FIFO_DEPTH = 32
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // Message framing from the terminal protocol core
    input wire logic msgStart,
    input wire logic msgTransmit,
    input wire logic [4:0] msgSubaddr,
    input wire logic [4:0] msgWordCount,
    input wire logic msgEnd,
    input wire logic msgBusy,
    input wire logic rxValid,
    input wire logic [15:0] rxWord,
    input wire logic txReq,
    output logic txValid,
    output logic [15:0] txWord,
    // Memory port
    output logic memWrite,
    output logic memRead,
    output logic [28:0] memAddr,
    output logic [31:0] memWdata,
    input wire logic [31:0] memRdata,
    // Status
    output logic headerReject,
    output logic checksumError,
    output logic statusRequest,
    output logic finalTransaction,
    output logic jumpRequest,
    output logic [28:0] jumpAddr,
    output logic [7:0] subPageCount,
    output logic [7:0] subPageFirst,
    output logic [1:0] transfer_mode_field,
    output logic [1:0] header_type_field,
    output logic [1:0] transfer_control_field,
    output logic [12:0] bufferCount
);
    initial begin
        if (FIFO_DEPTH != 32) $error("FIFO_DEPTH must be 32");
    end

    typedef enum {S_IDLE, S_HDR, S_LOAD, S_VERIFY, S_TRL, S_STAT} state_t;

    function automatic logic [12:0] countOf(input logic [15:0] w);
        countOf = (w[CNT_HI:0] == 12'h000) ? COUNT_ZERO_MEANS : {1'b0, w[CNT_HI:0]};
    endfunction

    // ----------------------------------------------------------------
    // Message state
    // ----------------------------------------------------------------
    state_t state, next_state;
    logic [2:0] wordIdx, next_wordIdx;
    logic [15:0] sum, next_sum;
    logic [15:0] hdr1, hdr2, hdr3, hdr4, next_hdr1, next_hdr2, next_hdr3, next_hdr4;
    logic [28:0] ptr, next_ptr, vStart, next_vStart;
    logic half, next_half, vHalf, next_vHalf;
    logic [15:0] lowHalf, next_lowHalf;
    logic [15:0] trl1, next_trl1;
    logic next_headerReject, next_checksumError, next_statusRequest;
    logic next_finalTransaction, next_jumpRequest;
    logic [28:0] next_jumpAddr;
    logic [7:0] next_subPageCount, next_subPageFirst;
    logic next_txValid;
    logic [15:0] next_txWord;
    logic fifoInValid, fifoInReady, fifoOutValid;
    logic [15:0] fifoOut;
    logic [1:0] tm;
    logic rxTake;
    logic [15:0] vSum, next_vSum;
    logic next_memWrite, next_memRead;
    logic [31:0] next_memWdata;
    logic [28:0] next_memAddr;
    logic [1:0] next_transfer_mode_field, next_header_type_field;
    logic [1:0] next_transfer_control_field;
    logic [12:0] next_bufferCount;

    // Load words wait in the FIFO; its ready gates the bus word strobe.
    data_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) loadFifo (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .inData(rxWord),
        .outValid(fifoOutValid),
        .outReady(1'b1),
        .outData(fifoOut)
    );

    assign tm = hdr1[TM_HI:TM_LO];
    assign fifoInValid = rxValid && state == S_LOAD;
    assign rxTake = rxValid && (state != S_LOAD || fifoInReady);

    always_comb begin
        next_state = state;
        next_wordIdx = wordIdx;
        next_sum = sum;
        next_hdr1 = hdr1;
        next_hdr2 = hdr2;
        next_hdr3 = hdr3;
        next_hdr4 = hdr4;
        next_ptr = ptr;
        next_vStart = vStart;
        next_half = half;
        next_vHalf = vHalf;
        next_lowHalf = lowHalf;
        next_trl1 = trl1;
        next_headerReject = headerReject;
        next_checksumError = checksumError;
        next_statusRequest = statusRequest;
        next_finalTransaction = finalTransaction;
        next_jumpRequest = 1'b0;
        next_jumpAddr = jumpAddr;
        next_subPageCount = subPageCount;
        next_subPageFirst = subPageFirst;
        next_txValid = 1'b0;
        next_txWord = txWord;
        next_vSum = vSum;
        next_memWrite = 1'b0;
        next_memRead = 1'b0;
        next_memWdata = memWdata;
        next_memAddr = ptr;
        next_transfer_mode_field = transfer_mode_field;
        next_header_type_field = header_type_field;
        next_transfer_control_field = transfer_control_field;
        next_bufferCount = bufferCount;
        if (msgStart) begin
            next_wordIdx = 3'h0;
            if (!msgTransmit && msgSubaddr == SA_HEADER) begin
                next_state = S_HDR;
                next_sum = SUM_RESET;
            end else if (!msgTransmit && msgSubaddr == SA_DATA) begin
                next_state = S_LOAD;
            end else if (msgTransmit && msgSubaddr == SA_DATA) begin
                next_state = S_VERIFY;
                // Remember where this verify began so a reissue replays it
                next_vStart = ptr;
                next_vHalf = half;
                next_vSum = sum;
            end else if (!msgTransmit && msgSubaddr == SA_TRAILER) begin
                next_state = S_TRL;
            end else if (msgTransmit && msgSubaddr == SA_STATUS) begin
                next_state = S_STAT;
            end else begin
                next_state = S_IDLE;
            end
        end else if (msgEnd) begin
            // A busy verify never counts: rewind so the retry resends it
            if (state == S_VERIFY && msgBusy) begin
                next_ptr = vStart;
                next_half = vHalf;
                // Discarded words must not stay in the running sum
                next_sum = vSum;
            end
            if (state == S_HDR) begin
                next_ptr = (tm == TM_NONE) ? 29'h0 : {hdr4[15:PAGE_LO], hdr2};
                next_half = 1'b0;
                next_headerReject = hdr4[1:0] == TC_BAD || hdr4[PAGE_ZERO_BIT]
                    || (tm != TM_NONE && hdr1[HT_HI:HT_LO] != HT_WORDS
                    && hdr1[HT_HI:HT_LO] != HT_MSGS);
                if (tm == TM_NONE) begin
                    next_jumpAddr = {hdr4[15:PAGE_LO], hdr3};
                end
                // Fields move with the reject flag, never ahead of it
                next_transfer_mode_field = tm;
                next_header_type_field = hdr1[HT_HI:HT_LO];
                next_transfer_control_field = hdr4[1:0];
                next_bufferCount = countOf(hdr1);
            end
            next_state = S_IDLE;
        end else if (rxTake) begin
            if (state == S_HDR || state == S_LOAD || (state == S_TRL && wordIdx == 3'h0)) begin
                next_sum = sum + rxWord;
            end
            case (state)
                S_HDR: begin
                    if (wordIdx == 3'h0) next_hdr1 = rxWord;
                    if (wordIdx == 3'h1) next_hdr2 = rxWord;
                    if (wordIdx == 3'h2) next_hdr3 = rxWord;
                    if (wordIdx == 3'h3) next_hdr4 = rxWord;
                    next_wordIdx = wordIdx + 3'h1;
                end
                S_TRL: begin
                    if (wordIdx == 3'h0) begin
                        next_trl1 = rxWord;
                    end else if (wordIdx == 3'h1) begin
                        next_checksumError = rxWord != sum;
                        next_statusRequest = rxWord != sum;
                        if (rxWord == sum) begin
                            next_subPageCount = trl1[15:SPC_LO];
                            next_subPageFirst = trl1[SPC_LO-1:0];
                        end
                        next_finalTransaction = hdr4[1:0] == TC_LAST;
                        // Control moves only once the trailer is in and good
                        next_jumpRequest = hdr4[1:0] == TC_JUMP && rxWord == sum
                            && !headerReject;
                    end
                    next_wordIdx = wordIdx + 3'h1;
                end
                default: begin
                end
            endcase
        end
        // Verify reads: checksum sums the words actually sent
        if (state == S_VERIFY && txReq && !msgStart && !msgEnd) begin
            next_txValid = 1'b1;
            next_txWord = (tm == TM_8) ? {8'h00, memRdata[7:0]} :
                (tm == TM_32 && half) ? memRdata[31:16] : memRdata[15:0];
            next_sum = sum + next_txWord;
            if (tm == TM_32 && !half) begin
                next_half = 1'b1;
            end else begin
                next_half = 1'b0;
                next_ptr = ptr + 29'h1;
            end
        end else if (state == S_STAT && txReq && !msgStart && !msgEnd) begin
            next_txValid = 1'b1;
            next_txWord = checksumError ? STATUS_ERR_RETRY : STATUS_OK;
            next_statusRequest = 1'b0;
        end
        // Memory writes drain the FIFO one word a cycle
        if (fifoOutValid && clkEn) begin
            if (tm == TM_32 && !half) begin
                next_lowHalf = fifoOut;
                next_half = 1'b1;
            end else begin
                next_memWrite = 1'b1;
                next_memWdata = (tm == TM_32) ? {fifoOut, lowHalf} :
                    (tm == TM_8) ? {24'h000000, fifoOut[7:0]} : {16'h0000, fifoOut};
                next_half = 1'b0;
                next_ptr = ptr + 29'h1;
            end
        end
        // A write carries the address it was drained for, not the next one
        next_memAddr = next_memWrite ? ptr : next_ptr;
        // Held through a verify so memRdata always follows memAddr
        next_memRead = next_state == S_VERIFY;
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state <= S_IDLE;
            wordIdx <= 3'h0;
            sum <= SUM_RESET;
            hdr1 <= 16'h0000;
            hdr2 <= 16'h0000;
            hdr3 <= 16'h0000;
            hdr4 <= 16'h0000;
            ptr <= 29'h0;
            vStart <= 29'h0;
            half <= 1'b0;
            vHalf <= 1'b0;
            lowHalf <= 16'h0000;
            trl1 <= 16'h0000;
            headerReject <= 1'b0;
            checksumError <= 1'b0;
            statusRequest <= 1'b0;
            finalTransaction <= 1'b0;
            jumpRequest <= 1'b0;
            jumpAddr <= 29'h0;
            subPageCount <= 8'h00;
            subPageFirst <= 8'h00;
            txValid <= 1'b0;
            txWord <= 16'h0000;
            memAddr <= 29'h0;
            memWrite <= 1'b0;
            memRead <= 1'b0;
            memWdata <= 32'h0000_0000;
            vSum <= SUM_RESET;
            transfer_mode_field <= 2'h0;
            header_type_field <= 2'h0;
            transfer_control_field <= 2'h0;
            bufferCount <= COUNT_ZERO_MEANS;
        end else if (clkEn) begin
            state <= next_state;
            wordIdx <= next_wordIdx;
            sum <= next_sum;
            hdr1 <= next_hdr1;
            hdr2 <= next_hdr2;
            hdr3 <= next_hdr3;
            hdr4 <= next_hdr4;
            ptr <= next_ptr;
            vStart <= next_vStart;
            half <= next_half;
            vHalf <= next_vHalf;
            lowHalf <= next_lowHalf;
            trl1 <= next_trl1;
            headerReject <= next_headerReject;
            checksumError <= next_checksumError;
            statusRequest <= next_statusRequest;
            finalTransaction <= next_finalTransaction;
            jumpRequest <= next_jumpRequest;
            jumpAddr <= next_jumpAddr;
            subPageCount <= next_subPageCount;
            subPageFirst <= next_subPageFirst;
            txValid <= next_txValid;
            txWord <= next_txWord;
            memAddr <= next_memAddr;
            memWrite <= next_memWrite;
            memRead <= next_memRead;
            memWdata <= next_memWdata;
            vSum <= next_vSum;
            transfer_mode_field <= next_transfer_mode_field;
            header_type_field <= next_header_type_field;
            transfer_control_field <= next_transfer_control_field;
            bufferCount <= next_bufferCount;
        end
    end
endmodule

// File: bench/reprog_monitor.sv
// Port checker for the reprogram transaction handler
`timescale 1ns/100ps
module reprog_monitor
    import reprog_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic txReq,
    input wire logic txValid,
    input wire logic memWrite,
    input wire logic headerReject,
    input wire logic checksumError,
    input wire logic statusRequest,
    input wire logic finalTransaction,
    input wire logic jumpRequest,
    input wire logic [1:0] transfer_mode_field,
    input wire logic [1:0] transfer_control_field,
    input wire logic [12:0] bufferCount
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_tx_answer;
        txReq && clkEn |=> txValid;
    endproperty
    a_tx_answer: assert property (p_tx_answer) else $error("no word after request");
    property p_tx_cause;
        txValid |-> $past(txReq);
    endproperty
    a_tx_cause: assert property (p_tx_cause) else $error("word without request");
    property p_count_range;
        bufferCount != 13'h0000 && bufferCount <= COUNT_ZERO_MEANS;
    endproperty
    a_count_range: assert property (p_count_range) else $error("count out of range");
    property p_reject_tc;
        transfer_control_field == TC_BAD |-> headerReject;
    endproperty
    a_reject_tc: assert property (p_reject_tc) else $error("control 11 kept");
    property p_jump_cond;
        jumpRequest |-> transfer_control_field == TC_JUMP && !checksumError && !headerReject;
    endproperty
    a_jump_cond: assert property (p_jump_cond) else $error("jump not allowed");
    property p_jump_pulse;
        jumpRequest |=> !jumpRequest;
    endproperty
    a_jump_pulse: assert property (p_jump_pulse) else $error("jump held");
    property p_status_err;
        $rose(checksumError) |-> statusRequest;
    endproperty
    a_status_err: assert property (p_status_err) else $error("no status request");
    property p_final;
        $rose(finalTransaction) |-> transfer_control_field == TC_LAST;
    endproperty
    a_final: assert property (p_final) else $error("final without 00");
    property p_mem_mode;
        memWrite |-> transfer_mode_field != TM_NONE;
    endproperty
    a_mem_mode: assert property (p_mem_mode) else $error("write in mode 00");
endmodule
bind reprogram_transaction_handler reprog_monitor u_reprog_monitor (
    .ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn), .txReq(txReq), .txValid(txValid),
    .memWrite(memWrite), .headerReject(headerReject), .checksumError(checksumError),
    .statusRequest(statusRequest), .finalTransaction(finalTransaction),
    .jumpRequest(jumpRequest), .transfer_mode_field(transfer_mode_field),
    .transfer_control_field(transfer_control_field), .bufferCount(bufferCount)
);

// File: bench/loader_model.sv
// Bus-controller loader model driving message framing
`timescale 1ns/100ps
module loader_model (
    input wire logic ref_clk,
    output logic msgStart,
    output logic msgTransmit,
    output logic [4:0] msgSubaddr,
    output logic [4:0] msgWordCount,
    output logic msgEnd,
    output logic msgBusy,
    output logic rxValid,
    output logic [15:0] rxWord,
    output logic txReq,
    input wire logic txValid,
    input wire logic [15:0] txWord
);
    initial begin
        {msgStart, msgTransmit, msgEnd, msgBusy, rxValid, txReq} = 6'h00;
        {msgSubaddr, msgWordCount} = 10'h000;
        rxWord = 16'h0000;
    end
    // Word count never above 32; data messages are full but the last
    task automatic start(input logic t, input logic [4:0] sa, input logic [4:0] wc);
        msgStart <= 1'h1;
        msgTransmit <= t;
        msgSubaddr <= sa;
        msgWordCount <= wc;
        @(posedge ref_clk);
        msgStart <= 1'h0;
        @(posedge ref_clk);
    endtask
    // A released data line shows the inverse, not the last word
    task automatic word(input logic [15:0] w);
        rxValid <= 1'h1;
        rxWord <= w;
        @(posedge ref_clk);
        rxValid <= 1'h0;
        rxWord <= ~w;
        @(posedge ref_clk);
    endtask
    // No activity poll before a trailer: this terminal reports busy in its status
    task automatic finish(input logic busy);
        msgEnd <= 1'h1;
        msgBusy <= busy;
        @(posedge ref_clk);
        msgEnd <= 1'h0;
        msgBusy <= 1'h0;
        @(posedge ref_clk);
    endtask
    task automatic req(output logic [15:0] w, output logic ok);
        txReq <= 1'h1;
        ok = 1'h0;
        w = 16'h0000;
        @(posedge ref_clk);
        txReq <= 1'h0;
        for (int i = 0; i < 3 && !ok; i++) begin
            #1;
            if (txValid === 1'h1) begin
                ok = 1'h1;
                w = txWord;
            end
            @(posedge ref_clk);
        end
    endtask
endmodule

// File: bench/tb.sv
// Self-checking bench for the reprogram transaction handler
`timescale 1ns/100ps
module tb;
    import reprog_pkg::*;
    logic ref_clk, rst_n, clkEn, msgStart, msgTransmit, msgEnd, msgBusy, rxValid, txReq;
    logic txValid, memWrite, memRead, headerReject, checksumError, statusRequest;
    logic finalTransaction, jumpRequest, jumpSeen, ok;
    logic [4:0] msgSubaddr, msgWordCount;
    logic [15:0] rxWord, txWord, sum, got;
    logic [28:0] memAddr, jumpAddr, lastA;
    logic [31:0] memWdata, lastW;
    logic [7:0] subPageCount, subPageFirst;
    logic [1:0] transfer_mode_field, header_type_field, transfer_control_field;
    logic [12:0] bufferCount;
    int fails, checks_done, wrCount;
    // Read data follows the address, so a verify that is not replayed shows
    wire logic [31:0] memRdata = {16'h1234, memAddr[15:0] + 16'h5a00};
    loader_model u_loader_model (.ref_clk, .msgStart, .msgTransmit, .msgSubaddr,
        .msgWordCount, .msgEnd, .msgBusy, .rxValid, .rxWord, .txReq, .txValid, .txWord);
    reprogram_transaction_handler #(.FIFO_DEPTH(32)) u_reprogram_transaction_handler (
        .ref_clk, .rst_n, .clkEn, .msgStart, .msgTransmit, .msgSubaddr, .msgWordCount,
        .msgEnd, .msgBusy, .rxValid, .rxWord, .txReq, .txValid, .txWord, .memWrite,
        .memRead, .memAddr, .memWdata, .memRdata, .headerReject, .checksumError,
        .statusRequest, .finalTransaction, .jumpRequest, .jumpAddr, .subPageCount,
        .subPageFirst, .transfer_mode_field, .header_type_field, .transfer_control_field,
        .bufferCount);
    initial begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (msgStart === 1'h1) begin
            wrCount <= 0;
            jumpSeen <= 1'h0;
        end
        if (memWrite === 1'h1) begin
            wrCount <= wrCount + 1;
            lastW <= memWdata;
            lastA <= memAddr;
        end
        if (jumpRequest === 1'h1) begin
            jumpSeen <= 1'h1;
        end
    end
    task automatic check(input logic [31:0] g, input logic [31:0] e, input string m);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("wrong value at %0t: %s got %h want %h", $time, m, g, e);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic rxw(input logic [15:0] w);
        sum = sum + w;
        u_loader_model.word(w);
    endtask
    task automatic header(input logic [1:0] m, h, input logic [11:0] c, input logic [15:0] la,
        ea, input logic [12:0] pg, input logic [1:0] tc, input logic b2);
        sum = SUM_RESET;
        u_loader_model.start(1'h0, SA_HEADER, 5'h04);
        rxw({m, h, c});
        rxw(la);
        rxw(ea);
        rxw({pg, b2, tc});
        u_loader_model.finish(1'h0);
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic trailer(input logic [15:0] w1, input logic [15:0] bad);
        u_loader_model.start(1'h0, SA_TRAILER, 5'h02);
        rxw(w1);
        u_loader_model.word(sum + bad);
        u_loader_model.finish(1'h0);
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic load(input logic [15:0] w[3], input int n);
        u_loader_model.start(1'h0, SA_DATA, 5'(n));
        for (int i = 0; i < n; i++) begin
            rxw(w[i]);
        end
        // Loads never draw busy here, so no resend is owed
        u_loader_model.finish(1'h0);
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic txmsg(input logic [4:0] sa, input int n, input logic busy,
        input logic [15:0] e);
        u_loader_model.start(1'h1, sa, 5'(n));
        for (int i = 0; i < n; i++) begin
            u_loader_model.req(got, ok);
            if (ok !== 1'h1) begin
                fails++;
                $display("wrong value at %0t: no transmit answer", $time);
                stop_test();
            end
            check(got, e + 16'(i), "sent word");
            if (sa == SA_DATA && !busy) begin
                sum = sum + e + 16'(i);
            end
        end
        u_loader_model.finish(busy);
        repeat (2) @(posedge ref_clk);
    endtask
    initial begin
        {rst_n, sum} = 17'h0;
        clkEn = 1'h1;
        {fails, checks_done} = 64'h0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'h1;
        @(posedge ref_clk);
        check(bufferCount, 13'h1000, "reset count");
        $display("test reset done");
        // Sub-page values go first through a header-trailer pair in mode 00
        header(TM_NONE, HT_WORDS, 12'h0, 16'h0, 16'h0123, 13'h5, TC_JUMP, 1'h0);
        check(jumpAddr, {13'h5, 16'h0123}, "entry");
        trailer(16'h0302, 16'h0);
        check(jumpSeen, 1'h1, "jump");
        check({subPageCount, subPageFirst}, 16'h0302, "sub-page");
        check(checksumError, 1'h0, "good sum");
        $display("test entry done");
        header(TM_16, HT_WORDS, 12'h0, 16'h0040, 16'h0, 13'h0, TC_MORE, 1'h0);
        check(bufferCount, 13'h1000, "zero count");
        check({transfer_mode_field, header_type_field}, {TM_16, HT_WORDS}, "mode");
        load('{16'h00a1, 16'h00a2, 16'h00a3}, 3);
        check(wrCount, 32'h3, "writes");
        check(lastW[15:0], 16'h00a3, "data");
        check(lastA, 32'h0000_0042, "address");
        trailer(16'h0, 16'h1);
        check({checksumError, statusRequest}, 2'h3, "bad sum");
        check(subPageCount, 8'h03, "sub-page kept");
        txmsg(SA_STATUS, 1, 1'h0, STATUS_ERR_RETRY);
        check(statusRequest, 1'h0, "served");
        $display("test load done");
        header(TM_16, HT_WORDS, 12'h2, 16'h0040, 16'h0, 13'h0, TC_LAST, 1'h0);
        txmsg(SA_DATA, 2, 1'h1, 16'h5a40);
        txmsg(SA_DATA, 2, 1'h0, 16'h5a40);
        trailer(16'h0, 16'h0);
        check(finalTransaction, 1'h1, "final");
        check(checksumError, 1'h0, "verify sum");
        $display("test verify done");
        header(TM_16, HT_WORDS, 12'h1, 16'h0, 16'h0, 13'h0, TC_BAD, 1'h0);
        check(headerReject, 1'h1, "control 11");
        header(TM_16, HT_WORDS, 12'h1, 16'h0, 16'h0, 13'h0, TC_MORE, 1'h1);
        check(headerReject, 1'h1, "bit 2");
        header(TM_16, 2'h2, 12'h1, 16'h0, 16'h0, 13'h0, TC_MORE, 1'h0);
        check(headerReject, 1'h1, "type 10");
        header(TM_8, HT_WORDS, 12'h1, 16'h0010, 16'h0, 13'h0, TC_MORE, 1'h0);
        load('{16'hff5c, 16'h0, 16'h0}, 1);
        check(lastW, 32'h0000_005c, "low byte");
        check(lastA, 32'h0000_0010, "byte address");
        header(TM_32, HT_MSGS, 12'h1, 16'h0, 16'h0, 13'h0, TC_MORE, 1'h0);
        check(headerReject, 1'h0, "type 01");
        load('{16'h1111, 16'h2222, 16'h0}, 2);
        check(wrCount, 32'h1, "one write");
        check(lastW, 32'h2222_1111, "halves");
        check(lastA, 32'h0000_0000, "pair address");
        $display("test modes done");
        stop_test();
    end
endmodule
